// ### eecc_ctrl.sv
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module eecc_ctrl
   import eecc_pkg::*;
#(
   parameter int WC_CYCLES  = WC_CYC,
   parameter int BLC_CYCLES = BLC_CYC
)(
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   // Register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   // Memory pins
   output eecc_pins_t       EE_PINS,
   input  wire logic [7:0]  EE_DQ_IN
);
   typedef struct packed {
      eecc_state_t st;
      logic [2:0]  cmd;
      logic [2:0]  seq_idx;
      logic [7:0]  scan;
      eecc_pins_t  pins;
      logic [16:0] poll_addr;
      logic        exp7;
      logic        exp_valid;
      logic        prev6;
      logic        have_prev;
      logic        fin;
      logic        wrote;
      logic        win_arm;
      logic [7:0]  rdata;
      logic        ctrl_prefix;
      logic        ctrl_id;
      logic [16:0] addr;
      logic [7:0]  wdata;
      logic [127:0] valid;
      logic [9:0]  page;
      logic        loaded;
      logic        f_timeout;
      logic        f_pageerr;
      logic        f_winmiss;
      logic        f_refused;
      logic        f_mismatch;
      logic [31:0] rd_out;
   } eecc_ctrl_t;

   eecc_ctrl_t       s_ff;
   eecc_ctrl_t       nxt_s;
   logic [7:0]       page_mem [128];
   logic             mem_we;
   logic             ph_load;
   logic [TMR_W-1:0] ph_val;
   logic             ph_done;
   logic             lt_load;
   logic [TMR_W-1:0] lt_val;
   logic             lt_done;
   logic [2:0]       seq_len;
   logic [31:0]      status;
   eecc_item_t       item;

   eecc_timer u_phase (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .load  (ph_load),
      .value (ph_val),
      .done  (ph_done)
   );

   eecc_timer u_long (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .load  (lt_load),
      .value (lt_val),
      .done  (lt_done)
   );

   always_comb begin
      nxt_s   = s_ff;
      mem_we  = 1'b0;
      ph_load = 1'b0;
      ph_val  = '0;
      lt_load = 1'b0;
      lt_val  = '0;
      item    = seq_item(s_ff.cmd == CMD_PROT_OF, s_ff.seq_idx);
      seq_len = 3'h0;
      if (s_ff.cmd == CMD_PROT_OF) begin
         seq_len = 3'(PROT_OF_LEN);
      end else if (s_ff.cmd == CMD_PROT_EN || s_ff.ctrl_prefix) begin
         seq_len = 3'(PROT_EN_LEN);
      end
      status = '0;
      status[ST_BUSY_BIT]     = (s_ff.st != S_IDLE);
      status[ST_TIMEOUT_BIT]  = s_ff.f_timeout;
      status[ST_PAGEERR_BIT]  = s_ff.f_pageerr;
      status[ST_WINMISS_BIT]  = s_ff.f_winmiss;
      status[ST_REFUSED_BIT]  = s_ff.f_refused;
      status[ST_MISMATCH_BIT] = s_ff.f_mismatch;
      status[ST_LOADED_BIT]   = s_ff.loaded;

      // Register reads, data one cycle later
      nxt_s.rd_out = '0;
      if (REG_RD) begin
         unique case (REG_ADDR)
            OFS_CTRL:   nxt_s.rd_out = {30'h0, s_ff.ctrl_id, s_ff.ctrl_prefix};
            OFS_ADDR:   nxt_s.rd_out = {15'h0, s_ff.addr};
            OFS_WDATA:  nxt_s.rd_out = {24'h0, s_ff.wdata};
            OFS_STATUS: nxt_s.rd_out = status;
            OFS_RDATA:  nxt_s.rd_out = {24'h0, s_ff.rdata};
            default:    nxt_s.rd_out = '0;
         endcase
      end

      // Register writes; flag clear by writing one
      if (REG_WR) begin
         unique case (REG_ADDR)
            OFS_CTRL: begin
               nxt_s.ctrl_prefix = REG_WDATA[CTRL_PREFIX_BIT];
               nxt_s.ctrl_id     = REG_WDATA[CTRL_ID_BIT];
            end
            OFS_ADDR:  nxt_s.addr  = REG_WDATA[16:0];
            OFS_WDATA: nxt_s.wdata = REG_WDATA[7:0];
            OFS_STATUS: begin
               if (REG_WDATA[ST_TIMEOUT_BIT])  nxt_s.f_timeout  = 1'b0;
               if (REG_WDATA[ST_PAGEERR_BIT])  nxt_s.f_pageerr  = 1'b0;
               if (REG_WDATA[ST_WINMISS_BIT])  nxt_s.f_winmiss  = 1'b0;
               if (REG_WDATA[ST_REFUSED_BIT])  nxt_s.f_refused  = 1'b0;
               if (REG_WDATA[ST_MISMATCH_BIT]) nxt_s.f_mismatch = 1'b0;
            end
            OFS_CMD: begin
               nxt_s.cmd = REG_WDATA[2:0];
               if (s_ff.st != S_IDLE) begin
                  nxt_s.f_refused = 1'b1;
                  nxt_s.cmd       = s_ff.cmd;
               end else if (REG_WDATA[2:0] == CMD_LOAD) begin
                  // One page only per load period
                  if (s_ff.loaded && s_ff.addr[16:7] != s_ff.page) begin
                     nxt_s.f_pageerr = 1'b1;
                  end else begin
                     mem_we = 1'b1;
                     nxt_s.valid[s_ff.addr[6:0]] = 1'b1;
                     nxt_s.page   = s_ff.addr[16:7];
                     nxt_s.loaded = 1'b1;
                  end
               end else if (REG_WDATA[2:0] == CMD_READ) begin
                  nxt_s.poll_addr = s_ff.addr;
                  nxt_s.pins.addr = s_ff.addr;
                  nxt_s.pins.ce_n = 1'b0;
                  nxt_s.pins.oe_n = 1'b0;
                  nxt_s.fin       = 1'b1;
                  ph_load = 1'b1;
                  ph_val  = TMR_W'(ACC_CYC);
                  nxt_s.st = S_RSET;
               end else if (REG_WDATA[2:0] == CMD_FLUSH || REG_WDATA[2:0] == CMD_PROT_EN ||
                            REG_WDATA[2:0] == CMD_PROT_OF) begin
                  nxt_s.seq_idx   = 3'h0;
                  nxt_s.scan      = 8'h00;
                  nxt_s.wrote     = 1'b0;
                  nxt_s.win_arm   = 1'b0;
                  nxt_s.exp_valid = 1'b0;
                  nxt_s.st        = S_SEQ;
               end else begin
                  nxt_s.f_refused = 1'b1;
               end
            end
            default: ;
         endcase
      end
      nxt_s.pins.id_hv = s_ff.ctrl_id;

      // Page bytes must follow each other inside the load window
      if (s_ff.win_arm && lt_done && s_ff.st inside {S_SEQ, S_WLOW, S_WHIGH}) begin
         nxt_s.f_winmiss = 1'b1;
      end

      unique case (s_ff.st)
         S_IDLE: ;
         S_SEQ: begin
            if (s_ff.seq_idx < seq_len) begin
               // Command bytes written with page timing, not kept
               nxt_s.pins.addr  = item.addr;
               nxt_s.pins.dq    = item.data;
               nxt_s.pins.dq_oe = 1'b1;
               nxt_s.pins.oe_n  = 1'b1;
               nxt_s.pins.ce_n  = 1'b0;
               nxt_s.pins.we_n  = 1'b0;
               nxt_s.seq_idx    = s_ff.seq_idx + 3'h1;
               nxt_s.exp_valid  = 1'b0;
               nxt_s.poll_addr  = item.addr;
               ph_load = 1'b1;
               ph_val  = TMR_W'(WP_CYC);
               nxt_s.st = S_WLOW;
            end else if (s_ff.cmd == CMD_FLUSH && !s_ff.scan[7]) begin
               nxt_s.scan = s_ff.scan + 8'h01;
               if (s_ff.valid[s_ff.scan[6:0]]) begin
                  // Only loaded bytes go out, one strobe each
                  nxt_s.valid[s_ff.scan[6:0]] = 1'b0;
                  nxt_s.pins.addr  = {s_ff.page, s_ff.scan[6:0]};
                  nxt_s.pins.dq    = page_mem[s_ff.scan[6:0]];
                  nxt_s.pins.dq_oe = 1'b1;
                  nxt_s.pins.oe_n  = 1'b1;
                  nxt_s.pins.ce_n  = 1'b0;
                  nxt_s.pins.we_n  = 1'b0;
                  nxt_s.exp7       = page_mem[s_ff.scan[6:0]][7];
                  nxt_s.exp_valid  = 1'b1;
                  nxt_s.poll_addr  = {s_ff.page, s_ff.scan[6:0]};
                  ph_load = 1'b1;
                  ph_val  = TMR_W'(WP_CYC);
                  nxt_s.st = S_WLOW;
               end
            end else if (!s_ff.wrote) begin
               nxt_s.loaded = 1'b0;
               nxt_s.st     = S_IDLE;
            end else begin
               // Device finishes by its own timer; watch with reads
               nxt_s.loaded    = 1'b0;
               nxt_s.win_arm   = 1'b0;
               nxt_s.have_prev = 1'b0;
               nxt_s.fin       = 1'b0;
               nxt_s.pins.addr = s_ff.poll_addr;
               nxt_s.pins.ce_n = 1'b0;
               nxt_s.pins.oe_n = 1'b0;
               lt_load = 1'b1;
               lt_val  = TMR_W'(WC_CYCLES);
               ph_load = 1'b1;
               ph_val  = TMR_W'(ACC_CYC);
               nxt_s.st = S_RSET;
            end
         end
         S_WLOW: begin
            if (ph_done) begin
               nxt_s.pins.we_n = 1'b1;
               ph_load = 1'b1;
               ph_val  = TMR_W'(WPH_CYC);
               nxt_s.st = S_WHIGH;
            end
         end
         S_WHIGH: begin
            if (ph_done) begin
               nxt_s.pins.ce_n  = 1'b1;
               nxt_s.pins.dq_oe = 1'b0;
               nxt_s.wrote      = 1'b1;
               nxt_s.win_arm    = 1'b1;
               lt_load = 1'b1;
               lt_val  = TMR_W'(BLC_CYCLES);
               nxt_s.st = S_SEQ;
            end
         end
         S_RSET: begin
            if (ph_done) begin
               nxt_s.pins.ce_n = 1'b1;
               nxt_s.pins.oe_n = 1'b1;
               nxt_s.rdata     = EE_DQ_IN;
               ph_load = 1'b1;
               ph_val  = TMR_W'(CEPH_CYC);
               nxt_s.st = S_RGAP;
               if (s_ff.cmd != CMD_READ) begin
                  nxt_s.prev6     = EE_DQ_IN[6];
                  nxt_s.have_prev = 1'b1;
                  if (s_ff.have_prev && EE_DQ_IN[6] == s_ff.prev6) begin
                     nxt_s.fin = 1'b1;
                     // Poll bit still inverted means nothing was stored
                     if (s_ff.exp_valid && EE_DQ_IN[7] != s_ff.exp7) begin
                        nxt_s.f_mismatch = 1'b1;
                     end
                  end else if (lt_done) begin
                     nxt_s.fin       = 1'b1;
                     nxt_s.f_timeout = 1'b1;
                  end
               end
            end
         end
         S_RGAP: begin
            if (ph_done) begin
               if (s_ff.fin) begin
                  nxt_s.st = S_IDLE;
               end else begin
                  nxt_s.pins.ce_n = 1'b0;
                  nxt_s.pins.oe_n = 1'b0;
                  ph_load = 1'b1;
                  ph_val  = TMR_W'(ACC_CYC);
                  nxt_s.st = S_RSET;
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         s_ff      <= '0;
         s_ff.pins <= PINS_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (mem_we) begin
         page_mem[s_ff.addr[6:0]] <= s_ff.wdata;
      end
   end

   assign REG_RDATA = s_ff.rd_out;
   assign EE_PINS   = s_ff.pins;
endmodule : eecc_ctrl

// ### eecc_pkg.sv
package eecc_pkg;

   // Register offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_CMD    = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_RDATA  = 8'h14;

   // Control fields
   localparam int CTRL_PREFIX_BIT = 0;
   localparam int CTRL_ID_BIT     = 1;

   // Status fields
   localparam int ST_BUSY_BIT     = 0;
   localparam int ST_TIMEOUT_BIT  = 1;
   localparam int ST_PAGEERR_BIT  = 2;
   localparam int ST_WINMISS_BIT  = 3;
   localparam int ST_REFUSED_BIT  = 4;
   localparam int ST_MISMATCH_BIT = 5;
   localparam int ST_LOADED_BIT   = 6;

   // Commands
   localparam logic [2:0] CMD_READ    = 3'h1;
   localparam logic [2:0] CMD_LOAD    = 3'h2;
   localparam logic [2:0] CMD_FLUSH   = 3'h3;
   localparam logic [2:0] CMD_PROT_EN = 3'h4;
   localparam logic [2:0] CMD_PROT_OF = 3'h5;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_WP_NS       = 100;
   localparam int T_WPH_NS      = 50;
   localparam int T_ACC_NS      = 120;
   localparam int T_CEPH_NS     = 50;
   localparam int T_WC_MS       = 10;
   localparam int T_BLC_US      = 150;
   localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPH_CYC  = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CEPH_CYC = (T_CEPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WC_CYC   = T_WC_MS * 1000000 / CLK_PERIOD_NS;
   localparam int BLC_CYC  = T_BLC_US * 1000 / CLK_PERIOD_NS;
   localparam int TMR_W    = 20;

   // Command sequence tables; values arbitrary, match to the attached part
   localparam int PROT_EN_LEN = 3;
   localparam int PROT_OF_LEN = 6;
   localparam logic [16:0] SEQ_ADDR_A = 17'h01111;
   localparam logic [16:0] SEQ_ADDR_B = 17'h00222;
   localparam logic [7:0]  SEQ_D_EN0  = 8'h11;
   localparam logic [7:0]  SEQ_D_EN1  = 8'h22;
   localparam logic [7:0]  SEQ_D_EN2  = 8'h33;
   localparam logic [7:0]  SEQ_D_OF3  = 8'h44;
   localparam logic [7:0]  SEQ_D_OF5  = 8'h55;

   typedef struct packed {
      logic [16:0] addr;
      logic [7:0]  dq;
      logic        dq_oe;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        id_hv;
   } eecc_pins_t;

   localparam eecc_pins_t PINS_IDLE = '{addr: 17'h00000, dq: 8'h00, dq_oe: 1'b0,
                                        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                        id_hv: 1'b0};

   typedef struct packed {
      logic [16:0] addr;
      logic [7:0]  data;
   } eecc_item_t;

   typedef enum logic [2:0] {S_IDLE, S_SEQ, S_WLOW, S_WHIGH, S_RSET, S_RGAP} eecc_state_t;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
   } eecc_tmr_t;

   function automatic eecc_item_t seq_item(input logic off, input logic [2:0] idx);
      eecc_item_t it;
      it.addr = (idx[0]) ? SEQ_ADDR_B : SEQ_ADDR_A;
      unique case (idx)
         3'h0:    it.data = SEQ_D_EN0;
         3'h1:    it.data = SEQ_D_EN1;
         3'h2:    it.data = off ? SEQ_D_OF3 : SEQ_D_EN2;
         3'h3:    it.data = SEQ_D_EN0;
         3'h4:    it.data = SEQ_D_EN1;
         default: it.data = SEQ_D_OF5;
      endcase
      return it;
   endfunction : seq_item

endpackage : eecc_pkg

// ### eecc_timer.sv
`timescale 1ns/1ps
module eecc_timer
   import eecc_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Control
   input  wire logic             load,
   input  wire logic [TMR_W-1:0] value,
   output logic                  done
);
   eecc_tmr_t s_ff;
   eecc_tmr_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (load) begin
         nxt_s.cnt = value;
      end else if (s_ff.cnt != '0) begin
         nxt_s.cnt = s_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign done = (s_ff.cnt == '0);
endmodule : eecc_timer

// ### eecc_ctrl_sva.sv
`timescale 1ns/1ps
module eecc_ctrl_sva
   import eecc_pkg::*;
(
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   // Register port
   input  wire logic        REG_RD,
   input  wire logic [31:0] REG_RDATA,
   // Memory pins
   input  wire eecc_pins_t  EE_PINS
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
      else $error("read data outside its cycle");
   no_contention_a: assert property (EE_PINS.dq_oe |-> EE_PINS.oe_n)
      else $error("data driven while device outputs enabled");
   write_inhibit_a: assert property (!EE_PINS.we_n |->
      EE_PINS.oe_n && !EE_PINS.ce_n && EE_PINS.dq_oe)
      else $error("write strobe low in a blocked state");
   wp_width_a: assert property ($fell(EE_PINS.we_n) |->
      (!EE_PINS.we_n) [*8] ##1 (!EE_PINS.we_n) [*2])
      else $error("write strobe low too short");
   wph_width_a: assert property ($rose(EE_PINS.we_n) |-> EE_PINS.we_n [*5])
      else $error("write strobe high too short");
   write_hold_a: assert property (!EE_PINS.we_n |=>
      $stable(EE_PINS.addr) && $stable(EE_PINS.dq))
      else $error("address or data moved during write");
   read_len_a: assert property ($fell(EE_PINS.oe_n) |->
      (!EE_PINS.oe_n && !EE_PINS.ce_n && EE_PINS.we_n) [*8] ##1
      (!EE_PINS.oe_n && !EE_PINS.ce_n && EE_PINS.we_n) [*4])
      else $error("read access too short");
   ceph_gap_a: assert property ($rose(EE_PINS.ce_n) && !$past(EE_PINS.oe_n) |->
      EE_PINS.ce_n [*5])
      else $error("chip select high too short after read");
endmodule : eecc_ctrl_sva

// ### eecc_mem_model.sv
`timescale 1ns/1ps
module eecc_mem_model
   import eecc_pkg::*;
#(
   parameter int WCM  = 60,
   parameter int BLCM = 250
)(
   // Clock
   input  wire logic       CLOCK,
   // Pins
   input  wire eecc_pins_t pins,
   input  wire logic [7:0] dq_bus,
   output logic [7:0]      dq_out,
   output logic            dq_drv
);
   logic [7:0]  mem [int];
   logic [7:0]  pg [int];
   logic [16:0] sa [6] = '{SEQ_ADDR_A, SEQ_ADDR_B, SEQ_ADDR_A, SEQ_ADDR_B, SEQ_ADDR_A, SEQ_ADDR_B};
   logic [7:0]  son [3] = '{SEQ_D_EN0, SEQ_D_EN1, SEQ_D_EN2};
   logic [7:0]  soff [6] = '{SEQ_D_EN0, SEQ_D_EN1, SEQ_D_OF3, SEQ_D_EN0, SEQ_D_EN1, SEQ_D_OF5};
   logic        wr_q = 1'b0, rd_q = 1'b0, prot = 1'b0, tog = 1'b0, onm = 1'b1, offm = 1'b1;
   logic [7:0]  last_d = 8'h00;
   int          blc = 0, wc = 0, k = 0, key = 0;
   wire         wr = !pins.ce_n && !pins.we_n && pins.oe_n;
   wire         rd = !pins.ce_n && !pins.oe_n && pins.we_n;

   // Id array sits above the main array
   function automatic int key_of(input eecc_pins_t p);
      return int'(p.addr) + ((p.id_hv && p.addr >= 17'h1ff80) ? 32'h20000 : 0);
   endfunction : key_of

   assign dq_drv = rd;
   always @(posedge CLOCK) begin
      wr_q <= wr;
      rd_q <= rd;
      if (wr && !wr_q) key = key_of(pins);
      if (!wr && wr_q && wc == 0) begin
         if (k < 6 && !(key == int'(sa[k]) && dq_bus == soff[k])) offm = 1'b0;
         if (k < 3 && !(key == int'(sa[k]) && dq_bus == son[k])) onm = 1'b0;
         if (!((k < 3 && onm) || (k < 6 && offm))) pg[key] = dq_bus;
         last_d = dq_bus;
         k = k + 1;
         blc = BLCM;
      end
      if (rd && !rd_q && wc > 0) tog <= ~tog;
      // A read closes the load period
      if (rd && !rd_q && blc > 0) blc = 1;
      if (blc > 0) begin
         blc = blc - 1;
         if (blc == 0) begin
            wc = WCM;
            if (offm && k >= 6) prot = 1'b0;
            else begin
               if (!prot || (onm && k >= 3)) foreach (pg[i]) mem[i] = pg[i];
               if (onm && k >= 3) prot = 1'b1;
            end
            pg.delete();
            k = 0;
            onm = 1'b1;
            offm = 1'b1;
         end
      end else if (wc > 0) wc = wc - 1;
      dq_out <= (wc > 0) ? {~last_d[7], tog, last_d[5:0]} :
                (mem.exists(key_of(pins)) ? mem[key_of(pins)] : 8'hff);
   end
endmodule : eecc_mem_model

// ### tb.sv
`timescale 1ns/1ps
bind eecc_ctrl eecc_ctrl_sva i_sva (.CLOCK(CLOCK), .RST_N(RST_N), .REG_RD(REG_RD),
                                    .REG_RDATA(REG_RDATA), .EE_PINS(EE_PINS));
module tb
   import eecc_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   eecc_pins_t  pins;
   logic [7:0]  mdq;
   logic [7:0]  dq_last = 8'h00;
   logic        mdrv;
   logic [31:0] rv;
   int          fail_count = 0;
   int          compares = 0;
   // Released line shows the inverse of its last level
   wire  [7:0]  dq_wire = pins.dq_oe ? pins.dq : (mdrv ? mdq : ~dq_last);

   initial forever #5 clock = ~clock;
   always @(posedge clock) dq_last <= dq_wire;

   eecc_ctrl #(.WC_CYCLES(200), .BLC_CYCLES(400)) i_dut (
      .CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .EE_PINS(pins),
      .EE_DQ_IN(dq_wire));
   eecc_mem_model #(.WCM(60), .BLCM(250)) i_mem (
      .CLOCK(clock), .pins(pins), .dq_bus(dq_wire), .dq_out(mdq), .dq_drv(mdrv));

   task automatic final_report;
      if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd_reg

   task automatic wait_idle;
      int n = 0;
      rd_reg(OFS_STATUS, rv);
      while (rv[ST_BUSY_BIT] !== 1'b0 && n < 3000) begin
         rd_reg(OFS_STATUS, rv);
         n++;
      end
      if (n >= 3000) begin
         fail_count++;
         $display("CHECK FAILED at %0t: busy stuck", $time);
      end
   endtask : wait_idle

   task automatic cmd(input logic [2:0] c);
      wr_reg(OFS_CMD, {29'h0, c});
      wait_idle();
   endtask : cmd

   task automatic ld(input logic [16:0] a, input logic [7:0] d);
      wr_reg(OFS_ADDR, {15'h0, a});
      wr_reg(OFS_WDATA, {24'h0, d});
      cmd(CMD_LOAD);
   endtask : ld

   task automatic flush(input logic [31:0] est);
      cmd(CMD_FLUSH);
      rd_reg(OFS_STATUS, rv);
      chk(rv & 32'h3e, est);
      wr_reg(OFS_STATUS, 32'h3e);
   endtask : flush

   task automatic rd_mem(input logic [16:0] a, input logic [7:0] e);
      wr_reg(OFS_ADDR, {15'h0, a});
      cmd(CMD_READ);
      rd_reg(OFS_RDATA, rv);
      chk(rv, {24'h0, e});
   endtask : rd_mem

   initial begin
      #500000;
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      final_report();
   end

   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      chk(32'(pins), 32'(PINS_IDLE));
      wr_reg(OFS_CTRL, 32'h3);
      rd_reg(OFS_CTRL, rv);
      chk(rv, 32'h3);
      rd_reg(8'h3c, rv);
      chk(rv, 32'h0);
      rd_reg(OFS_CMD, rv);
      chk(rv, 32'h0);
      wr_reg(OFS_CTRL, 32'h0);
      // Page load out of order with overwrite
      ld(17'h00285, 8'h5a);
      ld(17'h00281, 8'h11);
      ld(17'h00285, 8'ha5);
      flush(32'h0);
      rd_mem(17'h00285, 8'ha5);
      rd_mem(17'h00281, 8'h11);
      rd_mem(17'h00282, 8'hff);
      // Stray page byte dropped
      ld(17'h00300, 8'h01);
      ld(17'h00400, 8'h02);
      flush(32'h04);
      rd_mem(17'h00300, 8'h01);
      rd_mem(17'h00400, 8'hff);
      // Commands while busy and bad codes refused
      ld(17'h00700, 8'h0f);
      wr_reg(OFS_CMD, {29'h0, CMD_FLUSH});
      wr_reg(OFS_CMD, {29'h0, CMD_READ});
      wait_idle();
      wr_reg(OFS_CMD, 32'h7);
      rd_reg(OFS_STATUS, rv);
      chk(rv & 32'h3e, 32'h10);
      wr_reg(OFS_STATUS, 32'h3e);
      rd_mem(17'h00700, 8'h0f);
      // Write protection
      cmd(CMD_PROT_EN);
      chk({31'h0, i_mem.prot}, 32'h1);
      rd_mem(SEQ_ADDR_A, 8'hff);
      ld(17'h00500, 8'h77);
      flush(32'h20);
      rd_mem(17'h00500, 8'hff);
      wr_reg(OFS_CTRL, 32'h1);
      ld(17'h00500, 8'h77);
      flush(32'h0);
      rd_mem(17'h00500, 8'h77);
      // Controller reset leaves the device protected
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      chk(32'(pins), 32'(PINS_IDLE));
      chk({31'h0, i_mem.prot}, 32'h1);
      rd_reg(OFS_CTRL, rv);
      chk(rv, 32'h0);
      cmd(CMD_PROT_OF);
      chk({31'h0, i_mem.prot}, 32'h0);
      ld(17'h00600, 8'h42);
      flush(32'h0);
      rd_mem(17'h00600, 8'h42);
      // Id array
      wr_reg(OFS_CTRL, 32'h2);
      ld(17'h1ff85, 8'h3c);
      flush(32'h0);
      rd_mem(17'h1ff85, 8'h3c);
      wr_reg(OFS_CTRL, 32'h0);
      rd_mem(17'h1ff85, 8'hff);
      final_report();
   end
endmodule : tb
